// [hw/jpc_clamp_ctrl.sv]
// Jack pop clamp controller with AHB-Lite register slave
// Functional notes
// R1 - Force bit set makes the clamp active regardless of everything else.
// R2 - Force bit resets to one, so the clamp is active after reset.
// R3 - Mode 0 off, 1 on, 2-3 reserved, 4-7 single jack signal tests.
// R4 - Modes 8-B OR, C-F AND of both jack signals versus pattern.
// R5 - Clamp state shown at bit 4 of both raw status registers.
// R6 - Rise and fall of clamp state raise masked interrupt events.
// R7 - Rise or fall triggers the write sequencer when enabled; default off.
// R8 - Debounce bit set filters clamp state on the 32 kHz tick.
// R9 - In sleep the clamp keeps working without any debounce.
// R10 - Active clamp shorts mic sense pins A and B only.
// R11 - Switch code 00 open, 01 closed, 10 on clamp, 11 off clamp.
// R12 - Two switch fields at bits 1:0 and 3:2, reset to open.
// R13 - Software sets switch code 11 and a fitting mode for pop control.
// R14 - Jack sense signal reads one when its pin is pulled low.
// R15 - Clamp is force OR decoded condition; reserved codes give inactive.
// R16 - Edge events come from debounced state as one-cycle pulses.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module jpc_clamp_ctrl import jpc_pkg::*; #(
    parameter int DIV = SLOW_DIV,
    parameter int TICKS = DB_TICKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Jack sense pins, low when a plug is in
    input wire logic jack_sense_pin_a_n,
    input wire logic jack_sense_pin_b_n,
    // Power state
    input wire logic sleep_mode,
    // Clamp and switch drives
    output logic mic_short_en,
    output logic switch_a_closed,
    output logic switch_b_closed,
    // Events
    output logic irq,
    output logic seq_trigger_on_assert,
    output logic seq_trigger_on_release
);
    localparam int DW = $clog2(DIV);

    typedef struct packed {
        logic pa1, pa2, pb1, pb2, sl1, sl2;
        logic [DW-1:0] div;
        logic tick;
        logic clamp_force;
        logic [3:0] clamp_mode;
        logic [3:0] sw_ctl;
        logic clamp_debounce_enable;
        logic seq_trigger_on_assert_en;
        logic seq_trigger_on_release_en;
        logic [1:0] ev_sts;
        logic [1:0] ev_en;
        logic prev;
        logic mic;
        logic sw_a;
        logic sw_b;
        logic irq;
        logic seq_a;
        logic seq_r;
        jpc_bus_e ph;
        logic [15:0] aidx;
        logic amap;
        logic hready;
        logic [31:0] hrdata;
    } jpc_st_s;

    jpc_st_s st_r;
    jpc_st_s st_nxt;
    logic rs1_r;
    logic rst_q_n;
    logic jack_sense_a;
    logic jack_sense_b;
    logic clamp_raw;
    logic clamp_q;
    logic rise;
    logic fall;
    logic [1:0] wclr;
    logic [31:0] rdv;

    jpc_db_if db ();

    // Mode decode on the two jack signals
    function automatic logic clamp_cond(logic [3:0] m, logic a, logic b);
        logic ea;
        logic eb;
        ea = (a == m[1]);
        eb = (b == m[0]);
        clamp_cond = 1'b0;
        unique case (m[3:2])
            2'b00: clamp_cond = (m[1:0] == 2'b01); // [R3] [R15]
            2'b01: clamp_cond = m[1] ? (b == m[0]) : (a == m[0]); // [R3]
            2'b10: clamp_cond = ea | eb; // [R4]
            2'b11: clamp_cond = ea & eb; // [R4]
        endcase
    endfunction : clamp_cond

    // Switch position from its code and the clamp state
    function automatic logic sw_closed(jpc_sw_e m, logic c);
        sw_closed = 1'b0;
        unique case (m)
            SW_OPEN: sw_closed = 1'b0; // [R11]
            SW_CLOSED: sw_closed = 1'b1; // [R11]
            SW_ON_CLAMP: sw_closed = c; // [R11]
            SW_OFF_CLAMP: sw_closed = !c; // [R11] [R13]
        endcase
    endfunction : sw_closed

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_r <= 1'b0;
            rst_q_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_q_n <= rs1_r;
        end
    end

    // Inverted pins give active-high jack present
    assign jack_sense_a = !st_r.pa2; // [R14]
    assign jack_sense_b = !st_r.pb2; // [R14]
    assign clamp_raw = st_r.clamp_force | // [R1] [R15]
        clamp_cond(st_r.clamp_mode, jack_sense_a, jack_sense_b);
    assign clamp_q = db.filt;
    // Edges of the filtered state, so glitches raise no events while debounce is on outside sleep
    assign rise = clamp_q & !st_r.prev; // [R16]
    assign fall = !clamp_q & st_r.prev; // [R16]

    // Debounce filter hookup
    assign db.raw = clamp_raw;
    assign db.tick = st_r.tick;
    assign db.db_en = st_r.clamp_debounce_enable;
    assign db.sleep = st_r.sl2;

    jpc_debounce #(
        .TICKS(TICKS)
    ) u_db (
        .clk(clk),
        .rst_q_n(rst_q_n),
        .db(db)
    );

    // Register read mux; unmapped words read zero
    always_comb begin
        rdv = 32'h0;
        if (st_r.amap) begin
            unique case (st_r.aidx)
                IDX_SEQ: begin
                    rdv[SEQ_RISE_BIT] = st_r.seq_trigger_on_assert_en;
                    rdv[SEQ_FALL_BIT] = st_r.seq_trigger_on_release_en;
                end
                IDX_CLAMP: begin
                    rdv[FORCE_BIT] = st_r.clamp_force;
                    rdv[MODE_LSB +: 4] = st_r.clamp_mode;
                end
                IDX_SW: rdv[3:0] = st_r.sw_ctl;
                IDX_STS1: rdv[STS_BIT] = clamp_q; // [R5]
                IDX_STS2: rdv[STS_BIT] = clamp_q; // [R5]
                IDX_DB: rdv[DB_BIT] = st_r.clamp_debounce_enable;
                IDX_IRQ_STS: rdv[1:0] = st_r.ev_sts;
                IDX_IRQ_EN: rdv[1:0] = st_r.ev_en;
                default: rdv = 32'h0;
            endcase
        end
    end

    // Next-state logic for pins, divider, events and bus
    always_comb begin
        st_nxt = st_r;
        wclr = 2'h0;
        // Pin synchronisers
        st_nxt.pa1 = jack_sense_pin_a_n;
        st_nxt.pa2 = st_r.pa1;
        st_nxt.pb1 = jack_sense_pin_b_n;
        st_nxt.pb2 = st_r.pb1;
        st_nxt.sl1 = sleep_mode;
        st_nxt.sl2 = st_r.sl1;
        // Slow tick enable for the debounce filter
        st_nxt.tick = 1'b0;
        if (st_r.div == DW'(DIV - 1)) begin
            st_nxt.div = '0;
            st_nxt.tick = 1'b1; // [R8]
        end else begin
            st_nxt.div = st_r.div + DW'(1);
        end
        // Bus data phase
        unique case (st_r.ph)
            BUS_IDLE: ;
            BUS_WR: begin
                if (st_r.amap) begin
                    unique case (st_r.aidx)
                        IDX_SEQ: begin
                            st_nxt.seq_trigger_on_assert_en =
                                hwdata[SEQ_RISE_BIT];
                            st_nxt.seq_trigger_on_release_en =
                                hwdata[SEQ_FALL_BIT];
                        end
                        IDX_CLAMP: begin
                            st_nxt.clamp_force = hwdata[FORCE_BIT];
                            st_nxt.clamp_mode = hwdata[MODE_LSB +: 4];
                        end
                        IDX_SW: st_nxt.sw_ctl = hwdata[3:0]; // [R12]
                        IDX_DB: st_nxt.clamp_debounce_enable =
                            hwdata[DB_BIT];
                        IDX_IRQ_STS: wclr = hwdata[1:0];
                        IDX_IRQ_EN: st_nxt.ev_en = hwdata[1:0];
                        default: ;
                    endcase
                end
            end
            BUS_RD: begin
                st_nxt.hrdata = rdv;
                st_nxt.hready = 1'b1;
            end
            default: ;
        endcase
        // Address phase; reads get one wait state so data is fresh
        st_nxt.ph = BUS_IDLE;
        if (hsel && htrans[1] && hready && st_r.hready) begin
            st_nxt.aidx = haddr[17:2];
            st_nxt.amap = (haddr[31:18] == 14'h0);
            if (hwrite) begin
                st_nxt.ph = BUS_WR;
            end else begin
                st_nxt.ph = BUS_RD;
                st_nxt.hready = 1'b0;
            end
        end
        // Sticky events; a set in the clearing cycle wins
        st_nxt.prev = clamp_q;
        st_nxt.ev_sts = (st_r.ev_sts & ~wclr) | {fall, rise}; // [R6]
        st_nxt.irq = |(st_nxt.ev_sts & st_nxt.ev_en); // [R6] [R9]
        st_nxt.seq_a = rise & st_r.seq_trigger_on_assert_en; // [R7]
        st_nxt.seq_r = fall & st_r.seq_trigger_on_release_en; // [R7]
        // Pin drives follow the filtered clamp state
        st_nxt.mic = clamp_q; // [R10]
        st_nxt.sw_a = sw_closed(jpc_sw_e'(st_r.sw_ctl[SW_A_LSB +: 2]),
            clamp_q); // [R11]
        st_nxt.sw_b = sw_closed(jpc_sw_e'(st_r.sw_ctl[SW_B_LSB +: 2]),
            clamp_q); // [R11]
    end

    // State register; the clamp comes up forced on
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            st_r <= '0;
            st_r.clamp_force <= FORCE_RST; // [R2]
            st_r.clamp_mode <= MODE_RST;
            st_r.sw_ctl <= SW_RST; // [R12]
            st_r.pa1 <= 1'b1;
            st_r.pa2 <= 1'b1;
            st_r.pb1 <= 1'b1;
            st_r.pb2 <= 1'b1;
            st_r.ph <= BUS_IDLE;
            st_r.hready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops, except hresp tied low
    assign hreadyout = st_r.hready;
    assign hrdata = st_r.hrdata;
    assign hresp = 1'b0;
    assign mic_short_en = st_r.mic;
    assign switch_a_closed = st_r.sw_a;
    assign switch_b_closed = st_r.sw_b;
    assign irq = st_r.irq;
    assign seq_trigger_on_assert = st_r.seq_a;
    assign seq_trigger_on_release = st_r.seq_r;

    // Helper: low only in the first cycle after reset release
    logic seen_r;
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            seen_r <= 1'b0;
        end else begin
            seen_r <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q_n);

    // Gated by seen_r so the reset-release cycle cannot trip it
    property p_force;
        (seen_r && st_r.clamp_force && !st_r.clamp_debounce_enable) |=>
            clamp_q;
    endproperty
    a_force: assert property (p_force) // [R1]
        else $error("force bit set but clamp condition low");

    property p_rst_vals;
        !seen_r |-> st_r.clamp_force && st_r.sw_ctl == 4'h0;
    endproperty
    a_rst_vals: assert property (p_rst_vals) // [R2]
        else $error("wrong force or switch value after reset");

    property p_single;
        (!st_r.clamp_force && st_r.clamp_mode == 4'h4) |->
            (clamp_raw == st_r.pa2);
    endproperty
    a_single: assert property (p_single) // [R3]
        else $error("mode 4 does not follow jack A absent");

    property p_and;
        (!st_r.clamp_force && st_r.clamp_mode == 4'hF) |->
            (clamp_raw == (jack_sense_a && jack_sense_b));
    endproperty
    a_and: assert property (p_and) // [R4]
        else $error("mode F is not the AND of both jacks");

    property p_resv;
        (!st_r.clamp_force && st_r.clamp_mode[3:1] == 3'h1) |-> !clamp_raw;
    endproperty
    a_resv: assert property (p_resv) // [R15]
        else $error("reserved mode activated the clamp");

    property p_sts;
        (st_r.ph == BUS_RD && st_r.amap &&
            (st_r.aidx == IDX_STS1 || st_r.aidx == IDX_STS2)) |=>
            hreadyout && hrdata[STS_BIT] == $past(clamp_q);
    endproperty
    a_sts: assert property (p_sts) // [R5]
        else $error("status read does not show clamp state");

    property p_irq_rise;
        (rise && st_r.ev_en[EV_RISE]) |=> irq ##1 (irq || !st_r.ev_sts[0]);
    endproperty
    a_irq_rise: assert property (p_irq_rise) // [R6]
        else $error("rising clamp edge did not raise irq");

    property p_seq;
        fall |=> (seq_trigger_on_release == $past(st_r.seq_trigger_on_release_en))
            ##1 !seq_trigger_on_release;
    endproperty
    a_seq: assert property (p_seq) // [R7] [R16]
        else $error("release trigger not a gated one-cycle pulse");

    property p_sleep;
        (st_r.sl2 && $past(st_r.sl2)) |-> clamp_q == $past(clamp_raw);
    endproperty
    a_sleep: assert property (p_sleep) // [R9]
        else $error("clamp debounced while asleep");

    property p_short;
        ##1 (mic_short_en == $past(clamp_q));
    endproperty
    a_short: assert property (p_short) // [R10]
        else $error("mic short does not follow clamp");

    property p_sw_off;
        ($past(st_r.sw_ctl[1:0]) == 2'h3) |->
            switch_a_closed == !$past(clamp_q);
    endproperty
    a_sw_off: assert property (p_sw_off) // [R11]
        else $error("switch A not inverse of clamp in code 11");

    c_rise: cover property (rise ##[1:4] irq);
    c_fall: cover property (fall ##1 seq_trigger_on_release);
    c_sleep: cover property (st_r.sl2 && fall);
    c_db: cover property (st_r.clamp_debounce_enable && rise);
endmodule : jpc_clamp_ctrl

// [hw/jpc_pkg.sv]
// Shared constants and types for the jack pop clamp controller
package jpc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_SEQ = 16'h0041;
    localparam logic [15:0] IDX_CLAMP = 16'h02C6;
    localparam logic [15:0] IDX_SW = 16'h02C8;
    localparam logic [15:0] IDX_STS1 = 16'h1886;
    localparam logic [15:0] IDX_STS2 = 16'h1986;
    localparam logic [15:0] IDX_DB = 16'h1A06;
    localparam logic [15:0] IDX_IRQ_STS = 16'h1890;
    localparam logic [15:0] IDX_IRQ_EN = 16'h1891;
    // Field positions
    localparam int FORCE_BIT = 4;
    localparam int MODE_LSB = 0;
    localparam int STS_BIT = 4;
    localparam int DB_BIT = 4;
    localparam int SEQ_FALL_BIT = 0;
    localparam int SEQ_RISE_BIT = 1;
    localparam int SW_A_LSB = 0;
    localparam int SW_B_LSB = 2;
    localparam int EV_RISE = 0;
    localparam int EV_FALL = 1;
    // Reset values
    localparam logic FORCE_RST = 1'b1;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [3:0] SW_RST = 4'h0;
    // Timing: slow debounce clock derived from the core clock
    localparam int CLK_HZ = 50_000_000;
    localparam int SLOW_HZ = 32_000;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
    localparam int DB_TICKS = 4;
    // Switch control codes
    typedef enum logic [1:0] {
        SW_OPEN = 2'h0,
        SW_CLOSED = 2'h1,
        SW_ON_CLAMP = 2'h2,
        SW_OFF_CLAMP = 2'h3
    } jpc_sw_e;
    // Bus data-phase states, one-hot
    typedef enum logic [2:0] {
        BUS_IDLE = 3'h1,
        BUS_WR = 3'h2,
        BUS_RD = 3'h4
    } jpc_bus_e;
endpackage : jpc_pkg

// [hw/jpc_db_if.sv]
// Link between the clamp core and its debounce filter
`timescale 1ns/1ns
interface jpc_db_if;
    logic raw;
    logic tick;
    logic db_en;
    logic sleep;
    logic filt;
    modport core (output raw, output tick, output db_en, output sleep,
                  input filt);
    modport filt_side (input raw, input tick, input db_en, input sleep,
                       output filt);
endinterface : jpc_db_if

// [hw/jpc_debounce.sv]
// Debounce filter for the clamp condition, bypassed in sleep
`timescale 1ns/1ns
module jpc_debounce import jpc_pkg::*; #(
    parameter int TICKS = DB_TICKS
) (
    // Clock and synchronised reset
    input wire logic clk,
    input wire logic rst_q_n,
    // Core side
    jpc_db_if.filt_side db
);
    localparam int CW = $clog2(TICKS + 1);

    typedef struct packed {
        logic out;
        logic [CW-1:0] cnt;
    } jpc_dbst_s;

    jpc_dbst_s st_r;
    jpc_dbst_s st_nxt;

    // New level taken only after TICKS stable slow ticks
    always_comb begin
        st_nxt = st_r;
        if (db.sleep || !db.db_en) begin // [R9]
            st_nxt.out = db.raw;
            st_nxt.cnt = '0;
        end else if (db.raw == st_r.out) begin
            st_nxt.cnt = '0;
        end else if (db.tick) begin // [R8]
            if (st_r.cnt == CW'(TICKS - 1)) begin
                st_nxt.out = db.raw;
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + CW'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign db.filt = st_r.out;

    // Filtered level may only move on a tick while debouncing
    property p_db_hold;
        @(posedge clk) disable iff (!rst_q_n)
        (db.db_en && !db.sleep && !db.tick) |=> $stable(st_r.out);
    endproperty
    a_db_hold: assert property (p_db_hold) // [R8]
        else $error("debounced clamp moved without a slow tick");
endmodule : jpc_debounce

// [tb/jpc_jack_model.sv]
// Headset jack model: plug contacts pull the sense pins to ground
`timescale 1ns/1ns
module jpc_jack_model (
    // Plug state chosen by the bench
    input wire logic plug_a,
    input wire logic plug_b,
    // Sense pins, held high by the pull-up when no plug is in
    output logic pin_a_n,
    output logic pin_b_n
);
    // Inserted plug closes the contact to ground
    assign pin_a_n = plug_a ? 1'b0 : 1'b1;
    assign pin_b_n = plug_b ? 1'b0 : 1'b1;
endmodule : jpc_jack_model

// [tb/tb_jpc_clamp_ctrl.sv]
// Self-checking bench for the jack pop clamp controller
`timescale 1ns/1ns
module tb_jpc_clamp_ctrl import jpc_pkg::*; ();
    logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic plug_a, plug_b, pin_a_n, pin_b_n, sleep_mode;
    logic mic_short_en, sw_a, sw_b, irq, trg_as, trg_rel;
    logic [3:0] m;
    int mismatches, n_tests, n_rise, n_fall;
    // Rows: mode in the high nibble, clamp per jack pair {A,B} below
    localparam logic [7:0] ROWS [16] = '{8'h00, 8'h1F, 8'h20, 8'h30,
        8'h43, 8'h5C, 8'h65, 8'h7A, 8'h87, 8'h9B, 8'hAD, 8'hBE,
        8'hC1, 8'hD2, 8'hE4, 8'hF8};

    // Short debounce counts keep the run brief
    jpc_clamp_ctrl #(.DIV(8), .TICKS(2)) jpc_clamp_ctrl_i (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .jack_sense_pin_a_n(pin_a_n),
        .jack_sense_pin_b_n(pin_b_n), .sleep_mode(sleep_mode),
        .mic_short_en(mic_short_en), .switch_a_closed(sw_a),
        .switch_b_closed(sw_b), .irq(irq),
        .seq_trigger_on_assert(trg_as),
        .seq_trigger_on_release(trg_rel)
    );

    jpc_jack_model jpc_jack_model_i (
        .plug_a(plug_a), .plug_b(plug_b),
        .pin_a_n(pin_a_n), .pin_b_n(pin_b_n)
    );

    // Free-running core clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cycle count of each trigger pulse
    always @(posedge clk) begin
        if (trg_as === 1'b1) n_rise++;
        if (trg_rel === 1'b1) n_fall++;
    end

    task automatic results();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One single word transfer; entered just after a rising edge
    task automatic ahb(input logic w, input logic [15:0] idx,
                       input logic [31:0] d);
        int k;
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        q = hrdata;
        chk(32'(hresp), 32'h0, "hresp okay");
        chk(32'(k), w ? 32'h2 : 32'h3, "bus wait states");
        if (k >= 100) begin
            mismatches++;
            $display("[ERR] %0t bus never ready", $time);
            results();
        end
    endtask : ahb

    // Fixed settle covers sync, filter and output flops
    task automatic settle(input logic e);
        repeat (8) @(posedge clk);
        chk(32'(mic_short_en), 32'(e), "clamp state");
    endtask : settle

    // Bounded wait for the clamp to reach a level
    task automatic wait_clamp(input logic e, input int lim);
        int k;
        k = 0;
        while (mic_short_en !== e && k < lim) begin
            @(posedge clk);
            k++;
        end
        chk(32'(mic_short_en), 32'(e), "clamp timing");
    endtask : wait_clamp

    function automatic logic exp_sw(input logic [1:0] c, input logic cl);
        return c == 2'h1 || (c == 2'h2 && cl) || (c == 2'h3 && !cl);
    endfunction : exp_sw

    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        plug_a = 1'b0;
        plug_b = 1'b0;
        sleep_mode = 1'b0;
        mismatches = 0;
        n_tests = 0;
        n_rise = 0;
        n_fall = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        // Table: every mode against every jack pair
        for (int r = 0; r < 16; r++) begin
            m = ROWS[r][7:4];
            ahb(1'b1, IDX_CLAMP, {28'h0, m});
            for (int j = 0; j < 4; j++) begin
                plug_a <= j[1];
                plug_b <= j[0];
                settle(ROWS[r][j]);
                ahb(1'b0, IDX_STS1, 32'h0);
                chk(q & 32'h10, {27'h0, ROWS[r][j], 4'h0}, "sts1");
                ahb(1'b0, IDX_STS2, 32'h0);
                chk(q & 32'h10, {27'h0, ROWS[r][j], 4'h0}, "sts2");
            end
            ahb(1'b1, IDX_CLAMP, {28'h1, m});
            settle(1'b1);
        end
        chk(32'(n_rise + n_fall), 32'h0, "seq default");
        // Switch codes, B the mirror of A, with clamp on and off
        for (int c = 0; c < 4; c++) begin
            for (int cl = 0; cl < 2; cl++) begin
                ahb(1'b1, IDX_CLAMP, {27'h0, cl[0], 4'h0});
                ahb(1'b1, IDX_SW, {28'h0, c[1:0], 2'(3 - c)});
                settle(cl[0]);
                chk(32'(sw_b), 32'(exp_sw(c[1:0], cl[0])), "sw b");
                chk(32'(sw_a), 32'(exp_sw(2'(3 - c), cl[0])), "sw a");
            end
        end
        // Events: rise enabled only, then both
        ahb(1'b1, IDX_IRQ_STS, 32'h3);
        ahb(1'b1, IDX_IRQ_EN, 32'h1);
        ahb(1'b1, IDX_SEQ, 32'h3);
        ahb(1'b1, IDX_CLAMP, 32'h0);
        settle(1'b0);
        chk(32'(irq), 32'h0, "fall masked");
        chk(32'(n_fall), 32'h1, "fall pulse");
        ahb(1'b0, IDX_IRQ_STS, 32'h0);
        chk(q, 32'h2, "fall status");
        ahb(1'b1, IDX_CLAMP, 32'h1);
        settle(1'b1);
        chk(32'(irq), 32'h1, "rise irq");
        chk(32'(n_rise), 32'h1, "rise pulse");
        ahb(1'b1, IDX_IRQ_STS, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0, "rise cleared");
        ahb(1'b1, IDX_IRQ_EN, 32'h3);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1, "fall unmasked");
        ahb(1'b1, IDX_IRQ_STS, 32'h2);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0, "fall cleared");
        // Debounce: a glitch is swallowed, a steady change is late
        ahb(1'b1, IDX_CLAMP, 32'h4);
        plug_a <= 1'b1;
        settle(1'b0);
        ahb(1'b1, IDX_DB, 32'h10);
        plug_a <= 1'b0;
        repeat (2) @(posedge clk);
        plug_a <= 1'b1;
        repeat (30) @(posedge clk);
        chk(32'(mic_short_en), 32'h0, "glitch");
        plug_a <= 1'b0;
        repeat (6) @(posedge clk);
        chk(32'(mic_short_en), 32'h0, "filter hold");
        wait_clamp(1'b1, 40);
        // Pop setup: switch A opens while the clamp holds
        ahb(1'b1, IDX_SW, 32'h3);
        repeat (2) @(posedge clk);
        chk(32'(sw_a), 32'h0, "pop switch open");
        // Sleep bypasses the filter despite the enable bit
        sleep_mode <= 1'b1;
        repeat (4) @(posedge clk);
        plug_a <= 1'b1;
        wait_clamp(1'b0, 7);
        chk(32'(sw_a), 32'h1, "pop switch closed");
        // Mid-run reset: outputs drop, then the clamp comes back forced
        sleep_mode <= 1'b0;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(mic_short_en), 32'h0, "mic in reset");
        chk(32'({irq, sw_a, sw_b}), 32'h0, "outs in reset");
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        ahb(1'b0, IDX_CLAMP, 32'h0);
        chk(q, 32'h10, "clamp ctl reset");
        ahb(1'b0, IDX_SW, 32'h0);
        chk(q, 32'h0, "switch reset");
        ahb(1'b0, IDX_SEQ, 32'h0);
        chk(q, 32'h0, "seq reset");
        settle(1'b1);
        results();
    end
endmodule : tb_jpc_clamp_ctrl
